// ==== fcb_consts.vh ====
// constants for the flag conditional branch unit
`ifndef FCB_CONSTS_VH
`define FCB_CONSTS_VH
`define FCB_OP_NOV    8'hE5
`define FCB_OP_NZ     8'hE1
`define FCB_PC_STEP   21'h00_0002
`define FCB_PC_RST    21'h00_0000
`define FCB_Q1        4'h1
`define FCB_Q2        4'h2
`define FCB_Q3        4'h4
`define FCB_Q4        4'h8
`endif

// ==== fcb_branch.v ====
// flag conditional branch decode and execute unit
`timescale 1ns/1ns
`include "fcb_consts.vh"

module fcb_branch #(
	parameter PC_W = 21
) (
	input  wire            clk_i,
	input  wire            nrst_i,
	input  wire            instr_valid_i,
	input  wire [15:0]     instr_i,
	input  wire [PC_W-1:0] instr_addr_i,
	input  wire            ovf_flag_i,
	input  wire            zero_flag_i,
	output wire            is_branch_o,
	output reg  [PC_W-1:0] pc_o,
	output reg             pc_we_o,
	output reg             nop_cycle_o,
	output reg             done_o,
	output reg  [3:0]      qphase_o
);

	// ==========================================================
	// phase and state codes
	localparam [3:0] Q1     = `FCB_Q1;
	localparam [3:0] Q2     = `FCB_Q2;
	localparam [3:0] Q3     = `FCB_Q3;
	localparam [3:0] Q4     = `FCB_Q4;
	localparam [1:0] S_EXEC = 2'b01;
	localparam [1:0] S_NOP  = 2'b10;

	// ==========================================================
	// state and next values
	reg  [3:0]      q_q;
	reg  [3:0]      q_d;
	reg  [1:0]      st_q;
	reg  [1:0]      st_d;
	reg  [7:0]      off_q;
	reg  [7:0]      off_d;
	reg             take_q;
	reg             take_d;
	reg  [PC_W-1:0] addr_q;
	reg  [PC_W-1:0] addr_d;
	reg  [PC_W-1:0] pc_d;
	reg             pc_we_d;
	reg             done_d;
	reg             nop_d;

	wire            op_nov;
	wire            op_nz;
	wire            take;
	wire            latch_en;
	wire            exec_q4;
	wire            nop_q4;
	wire [PC_W-1:0] next_pc;
	wire [PC_W-1:0] disp;
	wire [PC_W-1:0] target;

	// ==========================================================
	// decode
	assign op_nov      = (instr_i[15:8] == `FCB_OP_NOV);
	assign op_nz       = (instr_i[15:8] == `FCB_OP_NZ);
	assign is_branch_o = instr_valid_i & (op_nov | op_nz);
	// flag inputs are the ones left by the last completed instruction
	assign take = (op_nov & ~ovf_flag_i) | (op_nz & ~zero_flag_i);

	assign latch_en = (st_q == S_EXEC) && (q_q == Q1);
	assign exec_q4  = (st_q == S_EXEC) && (q_q == Q4);
	assign nop_q4   = (st_q == S_NOP) && (q_q == Q4);

	// ==========================================================
	// target arithmetic
	assign next_pc = addr_q + `FCB_PC_STEP;

	// doubled, sign extended offset
	genvar gi;
	generate
		for (gi = 0; gi < PC_W; gi = gi + 1) begin : g_disp
			if (gi == 0) begin : g_lsb
				assign disp[gi] = 1'b0;
			end else if (gi < 9) begin : g_mid
				assign disp[gi] = off_q[gi-1];
			end else begin : g_sign
				assign disp[gi] = off_q[7];
			end
		end
	endgenerate

	assign target = next_pc + disp;

	// ==========================================================
	// quarter phase sequencer
	always @* begin
		case (q_q)
		Q1: begin
			q_d = Q2;
		end
		Q2: begin
			q_d = Q3;
		end
		Q3: begin
			q_d = Q4;
		end
		Q4: begin
			q_d = Q1;
		end
		default: begin
			q_d = Q1;
		end
		endcase
	end

	// ==========================================================
	// instruction cycle state
	always @* begin
		st_d = st_q;
		case (st_q)
		S_EXEC: begin
			if (exec_q4 && take_q) begin
				st_d = S_NOP;
			end
		end
		S_NOP: begin
			if (nop_q4) begin
				st_d = S_EXEC;
			end
		end
		default: begin
			st_d = S_EXEC;
		end
		endcase
	end

	// ==========================================================
	// literal and condition latch
	always @* begin
		off_d  = off_q;
		addr_d = addr_q;
		take_d = take_q;
		if (latch_en) begin
			off_d  = instr_i[7:0];
			addr_d = instr_addr_i;
			take_d = is_branch_o & take;
		end else if (nop_q4) begin
			take_d = 1'b0;
		end
	end

	// ==========================================================
	// pc write and completion
	always @* begin
		pc_d    = pc_o;
		pc_we_d = 1'b0;
		done_d  = 1'b0;
		if (exec_q4) begin
			pc_we_d = 1'b1;
			if (take_q) begin
				pc_d = target;
			end else begin
				pc_d   = next_pc;
				done_d = 1'b1;
			end
		end
		if (nop_q4) begin
			done_d = 1'b1;
		end
		nop_d = (st_d == S_NOP);
	end

	// ==========================================================
	// phase and state registers
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q_q  <= Q1;
			st_q <= S_EXEC;
		end else begin
			q_q  <= q_d;
			st_q <= st_d;
		end
	end

	// ==========================================================
	// latched literal, address and condition
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			off_q  <= 8'h00;
			addr_q <= `FCB_PC_RST;
			take_q <= 1'b0;
		end else begin
			off_q  <= off_d;
			addr_q <= addr_d;
			take_q <= take_d;
		end
	end

	// ==========================================================
	// program counter output
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pc_o <= `FCB_PC_RST;
		end else begin
			pc_o <= pc_d;
		end
	end

	// ==========================================================
	// program counter write strobe
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pc_we_o <= 1'b0;
		end else begin
			pc_we_o <= pc_we_d;
		end
	end

	// ==========================================================
	// completion strobe
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= done_d;
		end
	end

	// ==========================================================
	// no-op cycle flag
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nop_cycle_o <= 1'b0;
		end else begin
			nop_cycle_o <= nop_d;
		end
	end

	// ==========================================================
	// quarter phase output
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			qphase_o <= Q1;
		end else begin
			qphase_o <= q_d;
		end
	end

endmodule // fcb_branch

// ==== fcb_sva.sv ====
// branch checker
`timescale 1ns/1ns
module fcb_sva #(parameter PC_W=21)(input wire clk_i,nrst_i,pc_we_o,
nop_cycle_o,done_o,input wire [PC_W-1:0] pc_o);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
a_nop_span: assert property ($rose(nop_cycle_o)|->
nop_cycle_o[*4] ##1 !nop_cycle_o) else $error("nop");
a_nop_done: assert property ($fell(nop_cycle_o)|->done_o)
else $error("done");
a_we_pulse: assert property (pc_we_o|=>!pc_we_o[*3])
else $error("we");
a_pc_hold: assert property (!pc_we_o|->$stable(pc_o))
else $error("pc");
a_done_pulse: assert property (done_o|=>!done_o)
else $error("done pulse");
a_nop_after_we: assert property ($rose(nop_cycle_o)|->pc_we_o)
else $error("nop start");
endmodule // fcb_sva
bind fcb_branch fcb_sva #(.PC_W(PC_W)) u_sva (.*);

// ==== flag_conditional_branch_tb.sv ====
// branch unit bench
`timescale 1ns/1ns
module flag_conditional_branch_tb;
reg clk_i=0,nrst_i=0,instr_valid_i=0,ovf_flag_i=0,zero_flag_i=0;
reg [15:0] instr_i=0;
reg [20:0] instr_addr_i=21'h00_0100,t;
wire is_branch_o,pc_we_o,nop_cycle_o,done_o;
wire [20:0] pc_o;
wire [3:0] qphase_o;
integer miscompares=0,samples_checked=0,i,n;
reg [18:0] r,rows[8]='{{16'hE57F,3'b001},{16'hE580,3'b001},
{16'hE57F,3'b100},{16'hE1FF,3'b001},{16'hE1FF,3'b010},
{16'hE501,3'b011},{16'hE101,3'b101},{16'h0F00,3'b000}};
fcb_branch DUT (
	.clk_i         (clk_i),
	.nrst_i        (nrst_i),
	.instr_valid_i (instr_valid_i),
	.instr_i       (instr_i),
	.instr_addr_i  (instr_addr_i),
	.ovf_flag_i    (ovf_flag_i),
	.zero_flag_i   (zero_flag_i),
	.is_branch_o   (is_branch_o),
	.pc_o          (pc_o),
	.pc_we_o       (pc_we_o),
	.nop_cycle_o   (nop_cycle_o),
	.done_o        (done_o),
	.qphase_o      (qphase_o)
);
task chk(input [23:0] s,input [20:0] e,g);begin
samples_checked++;if(e!==g)begin miscompares++;
$display("FAIL %s exp %h got %h",s,e,g);end end endtask
task complete_run;begin
$display("miscompares %0d checked %0d",miscompares,samples_checked);
if(miscompares==0&&samples_checked>0)$display("ALL CHECKS OK");
else $display("CHECKS NOT OK");
$finish;end endtask
// one instruction, presented so that the next edge is an exec Q1
task run_row(input [18:0] rr);
begin
	n = 0;
	do begin
		@(negedge clk_i);
		n++;
	end while (qphase_o !== 4'h8 && n < 20);
	@(posedge clk_i);
	instr_i <= rr[18:3];
	instr_valid_i <= 1'b1;
	{ovf_flag_i, zero_flag_i} <= rr[2:1];
	@(negedge clk_i);
	chk("isb", rr[18:11] == 8'hE5 || rr[18:11] == 8'hE1, is_branch_o);
	@(posedge clk_i);
	instr_valid_i <= 1'b0;
	t = 21'h00_0102 + (rr[0] ? {{12{rr[10]}}, rr[10:3], 1'b0} : 21'h00_0000);
	n = 0;
	do begin
		@(negedge clk_i);
		n++;
	end while (pc_we_o !== 1'b1 && n < 20);
	chk("we", 1, pc_we_o);
	chk("pc", t, pc_o);
	chk("nop", rr[0], nop_cycle_o);
	n = 0;
	while (done_o !== 1'b1 && n < 9) begin
		@(negedge clk_i);
		n++;
	end
	chk("cyc", rr[0] ? 4 : 0, n[20:0]);
end
endtask
initial forever #2 clk_i=~clk_i;
initial begin #20000 miscompares++;complete_run;end
initial begin
	repeat (12) @(posedge clk_i);
	nrst_i <= 1'b1;
	for (i = 0; i < 8; i++) begin
		r = rows[i];
		run_row(r);
	end
	@(posedge clk_i);
	nrst_i <= 1'b0;
	@(negedge clk_i);
	chk("rst", 0, pc_o);
	chk("qph", 1, qphase_o);
	chk("rwe", 0, pc_we_o);
	@(posedge clk_i);
	nrst_i <= 1'b1;
	run_row({16'hE5FE, 3'b001});
	complete_run;
end
endmodule // flag_conditional_branch_tb
